// ==== bench/abmbd_ain_model.sv ====
// Analog input model: each channel gives its own distinct code
`timescale 1ns/1ps
module abmbd_ain_model (
  // Multiplexer select and converted value
  input wire [3:0] adcChannel_q,
  output wire [7:0] adcSample
);
  // Code follows the latched channel
  assign adcSample = {adcChannel_q, ~adcChannel_q};
endmodule // abmbd_ain_model

// ==== bench/abmbd_chk.sv ====
// Assertion checker for the analog module bus decoder
`timescale 1ns/1ps
module abmbd_chk #(
  parameter CONV_CYCLES = 20
) (
  // Clock and reset
  input wire sys_clk,
  input wire reset,
  // Host bus
  input wire [7:0] busIn,
  input wire busOe_q,
  input wire rdN,
  input wire wrN,
  // Converter side
  input wire [7:0] dacOutOne_q,
  input wire [7:0] dacOutTwo_q,
  input wire dacArmed_q,
  input wire dacReset_q,
  input wire [3:0] adcChannel_q,
  input wire adcReady_q,
  input wire adcReset_q
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  reg [15:0] lowCnt_q;
  // Low time of READY, cleared by any high cycle
  always @(posedge sys_clk)
    lowCnt_q <= adcReady_q ? 16'h0000 : lowCnt_q + 16'h0001;
  sequence readTaken; $rose(busOe_q); endsequence
  sequence convRuns; ##[1:3] !adcReady_q; endsequence
  AST_READ_STARTS: assert property (readTaken |-> convRuns) else $error("no conversion");
  AST_OE_CAUSE: assert property ($rose(busOe_q) |-> !$past(rdN, 2)) else $error("bus driven unasked");
  AST_READY_FALL: assert property ($fell(adcReady_q) |-> $past(busOe_q)) else $error("ready fell");
  AST_CONV_TIME: assert property ($rose(adcReady_q) |-> lowCnt_q >= CONV_CYCLES || adcReset_q || $past(adcReset_q))
    else $error("conversion short");
  AST_CHAN_LATCH: assert property ($changed(adcChannel_q) |-> $rose(busOe_q) || adcReset_q || $past(adcReset_q))
    else $error("channel moved");
  AST_DAC_LOAD: assert property ($changed({dacOutOne_q, dacOutTwo_q}) |-> !$past(wrN, 9) && !$past(wrN, 5))
    else $error("early latch load");
  AST_ARMED_SET: assert property ($rose(dacArmed_q) |-> !$past(wrN, 5) && $past(busIn, 5) == 8'h80)
    else $error("armed wrongly");
  AST_ARMED_CLR: assert property ($fell(dacArmed_q) |-> dacReset_q || $past(dacReset_q)) else $error("armed lost");
  AST_RST_PULSE: assert property (dacReset_q |=> !dacReset_q) else $error("long reset pulse");
endmodule // abmbd_chk
bind abmbd_top abmbd_chk #(.CONV_CYCLES(CONV_CYCLES)) i_abmbd_chk (.sys_clk, .reset, .busIn, .busOe_q, .rdN, .wrN,
  .dacOutOne_q, .dacOutTwo_q, .dacArmed_q, .dacReset_q, .adcChannel_q, .adcReady_q, .adcReset_q);

// ==== bench/abmbd_top_tb.sv ====
// Testbench for the analog module bus decoder
`timescale 1ns/1ps
`define CHK(n, e, g) compares++; if ((g) !== (e)) begin num_errors++; $display("[ERR] %s exp %h got %h", n, e, g); end
module abmbd_top_tb;
  typedef struct packed {logic rd; logic [7:0] a; logic [7:0] d; logic [16:0] e;} abmbd_row_t;
  reg sys_clk = 1'b0, reset = 1'b1, ale = 1'b0, rdN = 1'b1, wrN = 1'b1, dacHit = 1'b0, adcHit = 1'b0, rdOe;
  reg [7:0] busIn = 8'h00, rdDat;
  reg rdRdy, strapLow = 1'b0;
  wire [7:0] busOut_q, dacOutOne_q, dacOutTwo_q, adcSample;
  wire busOe_q, dacArmed_q, dacReset_q, adcReady_q, adcReset_q;
  wire [3:0] adcChannel_q;
  int num_errors = 0, compares = 0;
  // Reads give {drive, data, channel}, writes give {armed, out one, out two}
  abmbd_row_t rows [8] = '{{1'b1, 8'hB3, 8'h00, 1'b1, 8'h00, 8'h03}, {1'b1, 8'hB7, 8'h00, 1'b1, 8'h3C, 8'h07},
    {1'b1, 8'hB9, 8'h00, 1'b1, 8'h78, 8'h09}, {1'b0, 8'hB1, 8'h80, 1'b1, 8'h00, 8'h00},
    {1'b0, 8'hB0, 8'h11, 1'b1, 8'h11, 8'h00}, {1'b0, 8'hB2, 8'h22, 1'b1, 8'h11, 8'h22},
    {1'b0, 8'hB1, 8'h55, 1'b1, 8'h11, 8'h22}, {1'b0, 8'hB4, 8'h66, 1'b1, 8'h11, 8'h22}};
  abmbd_top #(.CONV_CYCLES(20)) i_abmbd_top (.sys_clk, .reset, .busIn, .busOut_q, .busOe_q, .ale, .rdN, .wrN,
    .hiAddr(7'h7F), .dacMatchStrapLow(strapLow), .dacMatchStrapHigh(1'b0), .adcStrap(11'h004), .dacOutOne_q,
    .dacOutTwo_q, .dacArmed_q, .dacReset_q, .adcSample, .adcChannel_q, .adcReady_q, .adcReset_q);
  abmbd_ain_model i_abmbd_ain_model (.adcChannel_q, .adcSample);
  always #12.5 sys_clk = ~sys_clk;
  // Reset pulses are one cycle wide, so keep a sticky record
  always @(posedge sys_clk)
  begin
    if (dacReset_q) dacHit <= 1'b1;
    if (adcReset_q) adcHit <= 1'b1;
  end
  task cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  // One external move: address phase, then a strobe held n cycles
  task acc(input logic rd, input logic [7:0] a, input logic [7:0] d, input int n);
    busIn = a;
    ale = 1'b1;
    cyc(2);
    ale = 1'b0;
    cyc(4);
    busIn = rd ? ~a : d; // Released bus shows the inverse of the address
    rdN = !rd;
    wrN = rd;
    cyc(n);
    rdOe = busOe_q;
    rdRdy = adcReady_q;
    rdDat = busOut_q;
    rdN = 1'b1;
    wrN = 1'b1;
    cyc(40); // Conversion wait before the next read
  endtask
  task final_report;
    $display("compares %0d errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial
  begin
    cyc(6);
    reset = 1'b0;
    cyc(6);
    `CHK("reset", 23'h000001, {busOut_q, busOe_q, dacOutOne_q, dacArmed_q, adcChannel_q, adcReady_q})
    // Data moves use the 10 page setup pattern first
    foreach (rows[i])
    begin
      acc(rows[i].rd, rows[i].a, rows[i].d, 12);
      `CHK("row", rows[i].e, rows[i].rd ? {rdOe, rdDat, 4'h0, adcChannel_q} : {dacArmed_q, dacOutOne_q, dacOutTwo_q})
    end
    acc(1'b0, 8'hB0, 8'h99, 3); // Store dropped before the delay ends
    `CHK("short store", {2'b00, 8'h11}, {dacHit, adcHit, dacOutOne_q})
    acc(1'b0, 8'h40, 8'h80, 12);
    `CHK("reset chans", {3'b110, 8'h11, 4'h0}, {dacHit, adcHit, dacArmed_q, dacOutOne_q, adcChannel_q})
    acc(1'b1, 8'hB5, 8'h00, 12);
    `CHK("read after reset", 8'h00, rdDat)
    `CHK("ready", 2'b01, {rdRdy, adcReady_q})
    // Mid-run reset clears latches and setup, READY idles high
    reset = 1'b1;
    cyc(2);
    reset = 1'b0;
    cyc(4);
    `CHK("mid reset", 18'h00001, {dacOutOne_q, dacOutTwo_q, dacArmed_q, adcReady_q})
    // Strap moved: A2 high now selects the D/A
    strapLow = 1'b1;
    cyc(1);
    acc(1'b0, 8'hB4, 8'h5A, 12);
    `CHK("strap", 8'h5A, dacOutOne_q)
    final_report;
  end
  initial
  begin
    #200us;
    num_errors++;
    final_report;
  end
endmodule // abmbd_top_tb

// ==== verilog/abmbd_consts.vh ====
// Constants for the analog module bus decoder
`ifndef ABMBD_CONSTS_VH
`define ABMBD_CONSTS_VH
// Clock period in ns (40 MHz)
`define ABMBD_CLK_NS 25
// Store strobe delay in ns, and in cycles (least time, rounded up)
`define ABMBD_WR_DELAY_NS 100
`define ABMBD_WR_DELAY_CYC ((`ABMBD_WR_DELAY_NS + `ABMBD_CLK_NS - 1) / `ABMBD_CLK_NS)
// Conversion time in ns at gain two, and in cycles (rounded up)
`define ABMBD_CONV_NS 35000
`define ABMBD_CONV_CYC ((`ABMBD_CONV_NS + `ABMBD_CLK_NS - 1) / `ABMBD_CLK_NS)
// Converter data channel offsets (low nibble) and upper nibble of the data page
`define ABMBD_OFS_OUT_ONE 8'hB0
`define ABMBD_OFS_INIT 8'hB1
`define ABMBD_OFS_OUT_TWO 8'hB2
// Address field positions
`define ABMBD_BIT_SETUP 0
`define ABMBD_BIT_OUTSEL 1
`define ABMBD_BIT_ADC_RST 7
`define ABMBD_BIT_DAC_RST 6
// Setup pattern that arms the D/A outputs
`define ABMBD_SETUP_PATTERN 8'h80
// Reset values
`define ABMBD_RST_BYTE 8'h00
`define ABMBD_RST_CHAN 4'h0
`endif

// ==== verilog/abmbd_conv.v ====
// Conversion timer for the A/D module: holds READY low while converting
`timescale 1ns/1ps
`include "abmbd_consts.vh"
module abmbd_conv #(
  parameter CONV_CYCLES = `ABMBD_CONV_CYC
) (
  // Clock and reset
  input wire sys_clk,
  input wire reset,
  // Control
  input wire start,
  input wire [7:0] sampleIn,
  // Status and result
  output reg busy_q,
  output reg [7:0] result_q
);
  reg [15:0] count_q;

  // Start reloads the count; a restart during a conversion begins afresh
  always @(posedge sys_clk)
  begin
    if (reset)
    begin
      busy_q <= 1'b0;
      count_q <= 16'h0000;
      result_q <= `ABMBD_RST_BYTE;
    end
    else if (start)
    begin
      busy_q <= 1'b1;
      count_q <= CONV_CYCLES[15:0] - 16'h0001;
    end
    else if (busy_q)
    begin
      if (count_q == 16'h0000)
      begin
        busy_q <= 1'b0;
        result_q <= sampleIn; // Sample taken at end of settling
      end
      else
        count_q <= count_q - 16'h0001;
    end
  end
endmodule // abmbd_conv

// ==== verilog/abmbd_top.v ====
// Bus decode and glue between a multiplexed 8-bit host bus and the D/A and A/D modules
`timescale 1ns/1ps
`include "abmbd_consts.vh"
module abmbd_top #(
  parameter CONV_CYCLES = `ABMBD_CONV_CYC,
  parameter WR_DELAY = `ABMBD_WR_DELAY_CYC
) (
  // Clock and reset
  input wire sys_clk,
  input wire reset,
  // Host bus pins
  input wire [7:0] busIn,
  output reg [7:0] busOut_q,
  output reg busOe_q,
  input wire ale,
  input wire rdN,
  input wire wrN,
  input wire [6:0] hiAddr,
  // Module straps
  input wire dacMatchStrapLow,
  input wire dacMatchStrapHigh,
  input wire [10:0] adcStrap,
  // D/A side
  output reg [7:0] dacOutOne_q,
  output reg [7:0] dacOutTwo_q,
  output reg dacArmed_q,
  output reg dacReset_q,
  // A/D side
  input wire [7:0] adcSample,
  output reg [3:0] adcChannel_q,
  output reg adcReady_q,
  output reg adcReset_q
);
  localparam SYNC_W = 11;
  localparam WS_IDLE = 2'b00;
  localparam WS_WAIT = 2'b01;
  localparam WS_HOLD = 2'b10;

  reg [SYNC_W-1:0] syncA_q;
  reg [SYNC_W-1:0] syncB_q;
  reg [SYNC_W-1:0] syncC_q;
  reg [SYNC_W-1:0] stable_q;
  reg [SYNC_W-1:0] prev_q;
  wire [SYNC_W-1:0] stable_d;
  wire [7:0] busS;
  wire aleFall;
  wire rdFall;
  wire rdRise;
  wire wrFall;
  wire wrRise;
  reg [7:0] addr_q;
  wire [13:0] fullAddr;
  wire rstChan;
  wire dacSel;
  wire adcSel;
  reg [1:0] wState_q;
  reg [7:0] wCount_q;
  reg wTarget_q;
  reg convStart_q;
  wire convBusy;
  wire [7:0] convResult;

  // True when the address field equals the compare pattern exactly, with no care mask
  function matchMasked;
    input [10:0] value;
    input [10:0] pattern;
    begin
      matchMasked = (value == pattern);
    end
  endfunction

  // Three-stage pin synchroniser; first stage feeds only the second
  always @(posedge sys_clk)
  begin
    syncA_q <= {ale, rdN, wrN, busIn};
    syncB_q <= syncA_q;
    syncC_q <= syncB_q;
  end

  // A level counts once stages two and three agree, rejecting single-cycle glitches
  assign stable_d = (syncB_q & ~(syncB_q ^ syncC_q)) | (stable_q & (syncB_q ^ syncC_q));

  always @(posedge sys_clk)
  begin
    if (reset)
    begin
      stable_q <= {1'b0, 1'b1, 1'b1, `ABMBD_RST_BYTE};
      prev_q <= {1'b0, 1'b1, 1'b1, `ABMBD_RST_BYTE};
    end
    else
    begin
      stable_q <= stable_d;
      prev_q <= stable_q;
    end
  end

  // Edge events on the filtered strobes
  assign busS = stable_q[7:0];
  assign aleFall = prev_q[10] & ~stable_q[10];
  assign rdFall = prev_q[9] & ~stable_q[9];
  assign rdRise = ~prev_q[9] & stable_q[9];
  assign wrFall = prev_q[8] & ~stable_q[8];
  assign wrRise = ~prev_q[8] & stable_q[8];

  // Address capture on the falling edge of the latch strobe
  always @(posedge sys_clk)
  begin
    if (reset)
      addr_q <= `ABMBD_RST_BYTE;
    else if (aleFall)
      addr_q <= busS;
  end

  // Address decode; board-tied upper lines extend the latched byte.
  // A6 reaches the D/A compare inverted, so the 10 data page shows all-high A4..A7 there
  assign fullAddr = {hiAddr[5:0], addr_q[7], ~addr_q[`ABMBD_BIT_DAC_RST], addr_q[5:0]};
  assign rstChan = ~addr_q[`ABMBD_BIT_ADC_RST] | addr_q[`ABMBD_BIT_DAC_RST];
  assign dacSel = ~rstChan & (fullAddr[3:2] == {dacMatchStrapHigh, dacMatchStrapLow})
    & (&fullAddr[13:4]);
  assign adcSel = ~rstChan & matchMasked({hiAddr, addr_q[7:4]}, ~adcStrap);

  // Reset channels pulse on a read or store strobe with A7 low (A/D) or A6 high (D/A) latched, regardless of data
  always @(posedge sys_clk)
  begin
    if (reset)
    begin
      adcReset_q <= 1'b0;
      dacReset_q <= 1'b0;
    end
    else
    begin
      adcReset_q <= (rdFall | wrFall) & ~addr_q[`ABMBD_BIT_ADC_RST];
      dacReset_q <= (rdFall | wrFall) & addr_q[`ABMBD_BIT_DAC_RST];
    end
  end

  // Delayed store strobe; the host must keep data on the bus past the delay
  always @(posedge sys_clk)
  begin
    if (reset)
    begin
      wState_q <= WS_IDLE;
      wCount_q <= 8'h00;
      wTarget_q <= 1'b0;
      dacOutOne_q <= `ABMBD_RST_BYTE;
      dacOutTwo_q <= `ABMBD_RST_BYTE;
      dacArmed_q <= 1'b0;
    end
    else if (dacReset_q)
    begin
      wState_q <= WS_IDLE;
      dacArmed_q <= 1'b0; // Setup needed again after reset
    end
    else
    begin
      case (wState_q)
        WS_IDLE:
        begin
          if (wrFall && dacSel)
          begin
            wState_q <= WS_WAIT;
            wCount_q <= WR_DELAY[7:0];
            wTarget_q <= addr_q[`ABMBD_BIT_OUTSEL];
          end
        end
        WS_WAIT:
        begin
          if (wrRise)
            wState_q <= WS_IDLE; // Strobe too short; nothing loads
          else if (wCount_q <= 8'h01)
          begin
            wState_q <= WS_HOLD;
            if (addr_q[`ABMBD_BIT_SETUP])
            begin
              if (busS == `ABMBD_SETUP_PATTERN)
                dacArmed_q <= 1'b1;
            end
            else if (wTarget_q)
              dacOutTwo_q <= busS;
            else
              dacOutOne_q <= busS;
          end
          else
            wCount_q <= wCount_q - 8'h01;
        end
        WS_HOLD:
        begin
          if (wrRise)
            wState_q <= WS_IDLE;
        end
        default:
          wState_q <= WS_IDLE;
      endcase
    end
  end

  // Read: drive the held result, latch the next channel, start conversion
  always @(posedge sys_clk)
  begin
    if (reset)
    begin
      busOut_q <= `ABMBD_RST_BYTE;
      busOe_q <= 1'b0;
      adcChannel_q <= `ABMBD_RST_CHAN;
      convStart_q <= 1'b0;
    end
    else
    begin
      convStart_q <= rdFall & adcSel & ~adcReset_q;
      if (adcReset_q)
      begin
        busOe_q <= 1'b0;
        adcChannel_q <= `ABMBD_RST_CHAN;
      end
      else if (rdFall && adcSel)
      begin
        busOut_q <= convResult;
        busOe_q <= 1'b1;
        adcChannel_q <= addr_q[3:0];
      end
      else if (rdRise)
        busOe_q <= 1'b0;
    end
  end

  // READY mirrors the conversion timer
  always @(posedge sys_clk)
  begin
    if (reset)
      adcReady_q <= 1'b1;
    else
      adcReady_q <= ~(convBusy | convStart_q);
  end

  abmbd_conv #(
    .CONV_CYCLES(CONV_CYCLES)
  ) uConv (
    .sys_clk(sys_clk),
    .reset(reset | adcReset_q),
    .start(convStart_q),
    .sampleIn(adcSample),
    .busy_q(convBusy),
    .result_q(convResult)
  );
endmodule // abmbd_top
